// ==== src/bpu_event_trig.v ====
// Event flags, interrupt request and converter trigger select of the basic pulse unit.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "bpu_event_map.vh"

module bpu_event_trig #(
  parameter NCH = 6,
  parameter NTRG = 4
) (
  input wire core_clk,
  input wire rst_n,
  input wire core_ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NCH-1:0] cmp_hit,
  input wire [NCH-1:0] cnt_down,
  input wire [NCH-1:0] cmp_eq_period,
  input wire [NCH-1:0] period_hit,
  input wire [NCH-1:0] zero_hit,
  input wire [2*NCH-1:0] cnt_type,
  input wire [NCH/2-1:0] comp_mode,
  output wire irq,
  output reg [NTRG-1:0] adc_trig
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  reg [NCH-1:0] cmpd_flag_q;
  reg [NCH-1:0] cmpd_flag_d;
  reg [NCH-1:0] cmpu_flag_q;
  reg [NCH-1:0] cmpu_flag_d;
  reg prd_flag_q;
  reg prd_flag_d;
  reg zero_flag_q;
  reg zero_flag_d;
  reg [31:0] irq_en_q;
  reg [31:0] irq_en_d;
  reg [31:0] trg_sel_q;
  reg [31:0] trg_sel_d;
  reg [31:0] rd_mux;
  reg [NTRG-1:0] adc_trig_d;
  reg irq_q;

  wire [NCH-1:0] up_evt;
  wire [NCH-1:0] down_evt;
  wire [NTRG-1:0] trg_hit;
  wire [31:0] flags_word;
  wire [31:0] pending_word;
  wire acc;
  wire wr_en;
  wire rd_setup;
  wire hit_irq_en;
  wire hit_flags;
  wire hit_pending;
  wire hit_trg_sel;
  wire mapped;
  wire [NCH-1:0] cmpd_clr;
  wire [NCH-1:0] cmpu_clr;
  wire prd_clr;
  wire zero_clr;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // The slave never stretches a transfer, but while the clock enable is
  // low it holds pready low so that no access completes against frozen state.
  assign pready = core_ce;
  assign acc = psel & penable & core_ce;
  assign wr_en = acc & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite & core_ce;

  assign hit_irq_en = (paddr == `BPU_OFS_IRQ_EN);
  assign hit_flags = (paddr == `BPU_OFS_FLAGS);
  assign hit_pending = (paddr == `BPU_OFS_PENDING);
  assign hit_trg_sel = (paddr == `BPU_OFS_TRG_SEL);
  assign mapped = hit_irq_en | hit_flags | hit_pending | hit_trg_sel;

  // Unmapped addresses answer with an error and leave every register alone.
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // Per-channel compare events
  // ----------------------------------------------------------------

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_evt
      localparam integer EVEN = i - (i % 2);
      localparam integer ODD = i % 2;
      wire dir_down;
      wire [1:0] typ;
      wire block_up;
      wire block_down;
      // (R05) odd channel follows even counter
      assign dir_down = (ODD == 1 && comp_mode[i/2]) ? cnt_down[EVEN] : cnt_down[i];
      assign typ = cnt_type[2*i +: 2];
      // (R04) suppress up flag
      assign block_up = cmp_eq_period[i] & (typ == `BPU_TYPE_UP);
      // (R02) suppress down flag
      assign block_down = cmp_eq_period[i] & (typ == `BPU_TYPE_DOWN);
      // (R03) up-count compare event
      assign up_evt[i] = cmp_hit[i] & ~dir_down & ~block_up;
      // (R01) down-count compare event
      assign down_evt[i] = cmp_hit[i] & dir_down & ~block_down;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------

  assign cmpd_clr = (wr_en & hit_flags) ? pwdata[`BPU_CMPD_LSB +: NCH] : {NCH{1'b0}};
  assign cmpu_clr = (wr_en & hit_flags) ? pwdata[`BPU_CMPU_LSB +: NCH] : {NCH{1'b0}};
  assign prd_clr = wr_en & hit_flags & pwdata[`BPU_PRD_BIT];
  assign zero_clr = wr_en & hit_flags & pwdata[`BPU_ZERO_BIT];

  // A flag that is set in the same cycle as its clearing write stays set,
  // so software never loses an event it has not yet seen.
  always @* begin
    // (R01) sticky down flags
    cmpd_flag_d = (cmpd_flag_q & ~cmpd_clr) | down_evt;
    // (R03) sticky up flags
    cmpu_flag_d = (cmpu_flag_q & ~cmpu_clr) | up_evt;
    // (R06) period point flag
    prd_flag_d = (prd_flag_q & ~prd_clr) | period_hit[0];
    // (R07) zero point flag
    zero_flag_d = (zero_flag_q & ~zero_clr) | zero_hit[0];
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      // (R13) flags clear at reset
      cmpd_flag_q <= {NCH{1'b0}};
      cmpu_flag_q <= {NCH{1'b0}};
      prd_flag_q <= 1'b0;
      zero_flag_q <= 1'b0;
    end else if (core_ce) begin
      cmpd_flag_q <= cmpd_flag_d;
      cmpu_flag_q <= cmpu_flag_d;
      prd_flag_q <= prd_flag_d;
      zero_flag_q <= zero_flag_d;
    end
  end

  // (R17) period strobe marks centre point in up-down mode
  assign flags_word = {{(32 - `BPU_CMPD_LSB - NCH){1'b0}}, cmpd_flag_q,
                       {(`BPU_CMPD_LSB - `BPU_CMPU_LSB - NCH){1'b0}}, cmpu_flag_q,
                       {(`BPU_CMPU_LSB - `BPU_PRD_BIT - 1){1'b0}}, prd_flag_q,
                       {(`BPU_PRD_BIT - `BPU_ZERO_BIT - 1){1'b0}}, zero_flag_q};

  // ----------------------------------------------------------------
  // Interrupt enable and request
  // ----------------------------------------------------------------

  always @* begin
    irq_en_d = irq_en_q;
    if (wr_en && hit_irq_en) begin
      // (R16) enable layout mirrors flags
      irq_en_d = pwdata & `BPU_IRQ_EN_WMASK;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      irq_en_q <= `BPU_RST_VAL;
    end else if (core_ce) begin
      irq_en_q <= irq_en_d;
    end
  end

  assign pending_word = flags_word & irq_en_q;

  // The request is registered so that it never glitches with the flag logic;
  // it is built from the next flag and enable values, so it changes on the same edge as the flag.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (core_ce) begin
      // (R15) any enabled flag raises request
      irq_q <= |(flags_word_next_masked(cmpd_flag_d, cmpu_flag_d, prd_flag_d,
                                        zero_flag_d) & irq_en_d);
    end
  end

  assign irq = irq_q;

  function [31:0] flags_word_next_masked;
    input [NCH-1:0] dn;
    input [NCH-1:0] up;
    input prd;
    input zero;
    begin
      flags_word_next_masked = `BPU_RST_VAL;
      flags_word_next_masked[`BPU_CMPD_LSB +: NCH] = dn;
      flags_word_next_masked[`BPU_CMPU_LSB +: NCH] = up;
      flags_word_next_masked[`BPU_PRD_BIT] = prd;
      flags_word_next_masked[`BPU_ZERO_BIT] = zero;
    end
  endfunction

  // ----------------------------------------------------------------
  // Converter trigger select
  // ----------------------------------------------------------------

  always @* begin
    trg_sel_d = trg_sel_q;
    if (wr_en && hit_trg_sel) begin
      // Reserved bits are not stored and read back as zero.
      trg_sel_d = pwdata & `BPU_TRG_SEL_WMASK;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      // (R13) triggers disabled at reset
      trg_sel_q <= `BPU_RST_VAL;
    end else if (core_ce) begin
      trg_sel_q <= trg_sel_d;
    end
  end

  genvar t;
  generate
    for (t = 0; t < NTRG; t = t + 1) begin : g_trg
      localparam integer BASE = t - (t % 2);
      localparam integer PAIR = BASE + 1;
      // Channel 2 has no codes for channel 3 events, so its high codes idle.
      localparam integer PAIRED = (t == 2) ? 0 : 1;
      // (R09) (R10) (R11) (R12) per-channel source decode
      bpu_trig_sel #(
        .HAS_PAIR(PAIRED)
      ) u_sel (
        .trg_en(trg_sel_q[t*`BPU_TRG_FIELD_W + `BPU_TRG_EN_BIT]),
        .trg_src(trg_sel_q[t*`BPU_TRG_FIELD_W +: 4]),
        .base_zero(zero_hit[BASE]),
        .base_prd(period_hit[BASE]),
        .base_up(up_evt[BASE]),
        .base_down(down_evt[BASE]),
        .pair_up(up_evt[PAIR]),
        .pair_down(down_evt[PAIR]),
        .trg_hit(trg_hit[t])
      );
    end
  endgenerate

  // Trigger pulses are registered: one cycle after the event, one cycle wide.
  always @* begin
    adc_trig_d = trg_hit;
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      adc_trig <= {NTRG{1'b0}};
    end else if (core_ce) begin
      // (R08) enabled triggers only
      adc_trig <= adc_trig_d;
    end else begin
      // A frozen block must not repeat a trigger pulse for every stalled cycle.
      adc_trig <= {NTRG{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  always @* begin
    rd_mux = `BPU_RST_VAL;
    case (paddr)
      `BPU_OFS_IRQ_EN: rd_mux = irq_en_q;
      `BPU_OFS_FLAGS: rd_mux = flags_word;
      `BPU_OFS_PENDING: rd_mux = pending_word;
      `BPU_OFS_TRG_SEL: rd_mux = trg_sel_q;
      default: rd_mux = `BPU_RST_VAL;
    endcase
  end

  // Read data is captured in the setup cycle, so a read shows the state
  // of the cycle before the access phase.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= `BPU_RST_VAL;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule

// ==== src/bpu_event_map.vh ====
// Register map, field positions and codes of the event flag and converter trigger block.
//
// Functional notes
// (R01) A channel counting down that reaches its compare value sets its compare-down flag; writing 1 clears it.
// (R02) With compare equal to period on a down-counting channel the compare-down flag is not raised.
// (R03) A channel counting up that reaches its compare value sets its compare-up flag; writing 1 clears it.
// (R04) With compare equal to period on an up-counting channel the compare-up flag is not raised.
// (R05) In complementary mode the odd-channel compare flags act as a second flag set of the even channel.
// (R06) Channel 0 reaching its period sets the period-point flag in bit 8; writing 1 clears it.
// (R07) Channel 0 reaching zero sets the zero-point flag in bit 0; writing 1 clears it.
// (R08) Each of channels 0 to 3 has a trigger enable bit at 7, 15, 23 and 31; no trigger without it.
// (R09) Channel 3 source codes 0 to 4 pick channel 2 events, codes 8 and 9 channel 3 compare events.
// (R10) Channel 2 source codes 0 to 4 pick channel 2 zero, period, either, up and down compare.
// (R11) Channel 1 source codes 0 to 4 pick channel 0 events, codes 8 and 9 channel 1 compare events.
// (R12) Channel 0 source field uses the same encoding as channel 1.
// (R13) After reset the trigger select and the flag register read all zeros.
// (R14) Reserved source codes never produce a converter trigger.
// (R15) The interrupt request is high while any flag is set together with its enable bit.
// (R16) Compare-down and compare-up enables sit at bits 29:24 and 21:16 of the enable register.
// (R17) In up-down counting the period point is the centre point of the counting cycle.
`ifndef BPU_EVENT_MAP_VH
`define BPU_EVENT_MAP_VH

`define BPU_ADDR_W 12
`define BPU_OFS_IRQ_EN 12'h0E0
`define BPU_OFS_FLAGS 12'h0E8
`define BPU_OFS_PENDING 12'h0EC
`define BPU_OFS_TRG_SEL 12'h0F8

`define BPU_RST_VAL 32'h00000000
`define BPU_IRQ_EN_WMASK 32'h3F3F0101
`define BPU_TRG_SEL_WMASK 32'h8F8F8F8F

`define BPU_CMPD_LSB 24
`define BPU_CMPU_LSB 16
`define BPU_PRD_BIT 8
`define BPU_ZERO_BIT 0
`define BPU_TRG_FIELD_W 8
`define BPU_TRG_EN_BIT 7

`define BPU_TYPE_UP 2'h0
`define BPU_TYPE_DOWN 2'h1
`define BPU_TYPE_UPDOWN 2'h2

`define BPU_SRC_ZERO 4'h0
`define BPU_SRC_PRD 4'h1
`define BPU_SRC_ZERO_PRD 4'h2
`define BPU_SRC_UP 4'h3
`define BPU_SRC_DOWN 4'h4
`define BPU_SRC_PAIR_UP 4'h8
`define BPU_SRC_PAIR_DOWN 4'h9

`endif

// ==== src/bpu_trig_sel.v ====
// Source decode of one converter trigger channel.
`timescale 1ns/1ns
`include "bpu_event_map.vh"

module bpu_trig_sel #(
  parameter HAS_PAIR = 1
) (
  input wire trg_en,
  input wire [3:0] trg_src,
  input wire base_zero,
  input wire base_prd,
  input wire base_up,
  input wire base_down,
  input wire pair_up,
  input wire pair_down,
  output reg trg_hit
);

  reg sel_evt;

  always @* begin
    sel_evt = 1'b0;
    case (trg_src)
      `BPU_SRC_ZERO: sel_evt = base_zero;
      `BPU_SRC_PRD: sel_evt = base_prd;
      `BPU_SRC_ZERO_PRD: sel_evt = base_zero | base_prd;
      `BPU_SRC_UP: sel_evt = base_up;
      `BPU_SRC_DOWN: sel_evt = base_down;
      `BPU_SRC_PAIR_UP: sel_evt = (HAS_PAIR != 0) & pair_up;
      `BPU_SRC_PAIR_DOWN: sel_evt = (HAS_PAIR != 0) & pair_down;
      // (R14) reserved codes idle
      default: sel_evt = 1'b0;
    endcase
    // (R08) enable gates trigger
    trg_hit = trg_en & sel_evt;
  end

endmodule

// ==== verif/bpu_event_chk.sv ====
// Port-level assertions of the event flag and converter trigger block.
`timescale 1ns/1ns
module bpu_event_chk #(parameter NCH = 6, parameter NTRG = 4) (
  input logic core_clk,
  input logic rst_n,
  input logic core_ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic [NCH-1:0] cmp_hit,
  input logic [NCH-1:0] period_hit,
  input logic [NCH-1:0] zero_hit,
  input logic irq,
  input logic [NTRG-1:0] adc_trig
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Any trigger must trace back to a counter event taken with the clock enabled.
  wire ev0 = core_ce && (zero_hit[0] || period_hit[0] || |cmp_hit[1:0]);
  wire ev2 = core_ce && (zero_hit[2] || period_hit[2] || cmp_hit[2]);
  wire ev3 = core_ce && (zero_hit[2] || period_hit[2] || |cmp_hit[3:2]);
  wire wr = psel && penable && pwrite && core_ce;
  sequence rd_setup;
    psel && !penable && !pwrite && core_ce;
  endsequence
  sequence bad_access;
    psel && penable && pslverr;
  endsequence
  trig_zero_a: assert property (adc_trig[0] |-> $past(ev0))
    else $error("trigger 0 without event");
  trig_one_a: assert property (adc_trig[1] |-> $past(ev0))
    else $error("trigger 1 without event");
  trig_two_a: assert property (adc_trig[2] |-> $past(ev2))
    else $error("trigger 2 without event");
  trig_three_a: assert property (adc_trig[3] |-> $past(ev3))
    else $error("trigger 3 without event");
  irq_rise_a: assert property ($rose(irq) |-> $past(ev0 || |cmp_hit || wr))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr))
    else $error("irq fell without write");
  irq_frozen_a: assert property (!core_ce |=> $stable(irq))
    else $error("irq moved with clock enable low");
  unmapped_zero_a: assert property (rd_setup ##1 bad_access |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// ==== verif/bpu_adc_model.sv ====
// Converter side model that counts trigger pulses per channel.
`timescale 1ns/1ns
module bpu_adc_model (
  input logic core_clk,
  input logic rst_n,
  input logic [3:0] adc_trig,
  output logic [31:0] n_trig
);
  integer t;
  // ----------------------------------------
  // Pulse counters
  // ----------------------------------------
  // Counted per edge, so a stretched pulse shows up as an extra conversion.
  always @(posedge core_clk) begin
    if (!rst_n) n_trig <= 32'h0;
    else for (t = 0; t < 4; t = t + 1) n_trig[8*t +: 8] <= n_trig[8*t +: 8] + adc_trig[t];
  end
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench of the event flag and converter trigger block.
`timescale 1ns/1ns
`include "bpu_event_map.vh"
module tb;
  reg core_clk = 0, rst_n = 0, core_ce = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h0, cnt_type = 12'h0;
  reg [31:0] pwdata = 32'h0, rd, exp_trig = 32'h0;
  reg [5:0] cmp_hit = 6'h0, cnt_down = 6'h0, cmp_eq_period = 6'h0, period_hit = 6'h0;
  reg [5:0] zero_hit = 6'h0;
  reg [2:0] comp_mode = 3'h0;
  reg err;
  wire [31:0] prdata, n_trig;
  wire pready, pslverr, irq;
  wire [3:0] adc_trig;
  integer miscompares = 0, n_compared = 0, i, k, t;
  always #50 core_clk = ~core_clk;
  bpu_event_trig bpu_event_trig_inst (.core_clk(core_clk), .rst_n(rst_n), .core_ce(core_ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_hit(cmp_hit),
    .cnt_down(cnt_down), .cmp_eq_period(cmp_eq_period), .period_hit(period_hit),
    .zero_hit(zero_hit), .cnt_type(cnt_type), .comp_mode(comp_mode), .irq(irq),
    .adc_trig(adc_trig));
  bpu_adc_model bpu_adc_model_inst (.core_clk(core_clk), .rst_n(rst_n), .adc_trig(adc_trig),
    .n_trig(n_trig));
  task chk(input [31:0] seen, input [31:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Bus cycle; the wait for pready is bounded so a dead slave ends the run.
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge core_clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
        miscompares = miscompares + 1;
        end_sim;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task ev(input [5:0] ch, input [5:0] dn, input [5:0] pr, input [5:0] z);
    begin
      @(posedge core_clk);
      cmp_hit <= ch;
      cnt_down <= dn;
      period_hit <= pr;
      zero_hit <= z;
      @(posedge core_clk);
      cmp_hit <= 6'h0;
      period_hit <= 6'h0;
      zero_hit <= 6'h0;
    end
  endtask
  task fcase(input [5:0] ch, dn, eq, input [11:0] ty, input [2:0] cm, input [31:0] want);
    begin
      cnt_type <= ty;
      comp_mode <= cm;
      cmp_eq_period <= eq;
      ev(ch, dn, {5'h0, want[8]}, {5'h0, want[0]});
      apb(0, `BPU_OFS_FLAGS, 32'h0);
      chk(rd, want);
      apb(1, `BPU_OFS_FLAGS, 32'hFFFFFFFF);
    end
  endtask
  function hit(input [3:0] c, input integer k, input integer t);
    hit = (c == 0 && k == 0) || (c == 1 && k == 1) || (c == 2 && k < 2) || (c == 3 && k == 2)
      || (c == 4 && k == 3) || (t != 2 && ((c == 8 && k == 4) || (c == 9 && k == 5)));
  endfunction
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
    apb(0, `BPU_OFS_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(0, `BPU_OFS_TRG_SEL, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    fcase(6'h3F, 6'h00, 6'h00, 12'h000, 3'h0, 32'h003F0000);
    fcase(6'h3F, 6'h3F, 6'h00, 12'h000, 3'h0, 32'h3F000000);
    fcase(6'h3F, 6'h00, 6'h3F, 12'h000, 3'h0, 32'h00000000);
    fcase(6'h3F, 6'h3F, 6'h3F, 12'h555, 3'h0, 32'h00000000);
    fcase(6'h3F, 6'h3F, 6'h3F, 12'hAAA, 3'h0, 32'h3F000000);
    fcase(6'h00, 6'h00, 6'h00, 12'h000, 3'h0, 32'h00000101);
    fcase(6'h02, 6'h01, 6'h00, 12'h000, 3'h1, 32'h02000000);
    $display("flag test done");
    apb(1, `BPU_OFS_IRQ_EN, 32'hFFFFFFFF);
    apb(0, `BPU_OFS_IRQ_EN, 32'h0);
    chk(rd, 32'h3F3F0101);
    apb(1, `BPU_OFS_IRQ_EN, 32'h00040000);
    ev(6'h06, 6'h00, 6'h00, 6'h00);
    @(posedge core_clk);
    chk(irq, 32'h1);
    apb(1, `BPU_OFS_FLAGS, 32'h00040000);
    apb(0, `BPU_OFS_FLAGS, 32'h0);
    chk(rd, 32'h00020000);
    chk(irq, 32'h0);
    apb(1, `BPU_OFS_IRQ_EN, 32'h0);
    apb(1, `BPU_OFS_FLAGS, 32'hFFFFFFFF);
    core_ce <= 0;
    ev(6'h00, 6'h00, 6'h00, 6'h01);
    core_ce <= 1;
    apb(0, `BPU_OFS_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("irq and bus test done");
    apb(1, `BPU_OFS_TRG_SEL, 32'hFFFFFFFF);
    apb(0, `BPU_OFS_TRG_SEL, 32'h0);
    chk(rd, 32'h8F8F8F8F);
    // Upper half of the loop repeats every code with the enable bits clear.
    for (i = 0; i < 32; i = i + 1) begin
      apb(1, `BPU_OFS_TRG_SEL, {4{~i[4], 3'h0, i[3:0]}});
      for (k = 0; k < 6; k = k + 1) begin
        ev((k == 2 || k == 3) ? 6'h05 : (k > 3) ? 6'h0A : 6'h00,
          (k == 3 || k == 5) ? 6'h3F : 6'h00, (k == 1) ? 6'h3F : 6'h00, (k == 0) ? 6'h3F : 6'h00);
        for (t = 0; t < 4; t = t + 1)
          if (!i[4] && hit(i[3:0], k, t)) exp_trig[8*t +: 8] = exp_trig[8*t +: 8] + 1;
      end
      repeat (2) @(posedge core_clk);
      chk(n_trig, exp_trig);
    end
    $display("trigger test done");
    end_sim;
  end
endmodule
bind bpu_event_trig bpu_event_chk #(.NCH(NCH), .NTRG(NTRG)) bpu_event_chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .core_ce(core_ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .cmp_hit(cmp_hit),
  .period_hit(period_hit), .zero_hit(zero_hit), .irq(irq), .adc_trig(adc_trig));
